/* File: hw/dspwm_map.vh */
`ifndef DSPWM_MAP_VH
`define DSPWM_MAP_VH
// Data space layout
`define DSPWM_EA_W          16
`define DSPWM_DATA_W        16
`define DSPWM_PWORD_W       24
`define DSPWM_PADDR_W       23
`define DSPWM_PAGE_W        8
`define DSPWM_WIN_BIT       15
`define DSPWM_LOW_BITS      15
`define DSPWM_BYTE_W        8
`define DSPWM_BYTE_SEL      0
// Implemented memory and fixed X/Y partition (word-aligned byte addresses)
`define DSPWM_IMPL_LO       16'h0000
`define DSPWM_IMPL_HI       16'h27ff
`define DSPWM_Y_LO          16'h1800
`define DSPWM_Y_HI          16'h27ff
// Instruction classes
`define DSPWM_CLS_OTHER     2'h0
`define DSPWM_CLS_MAC       2'h1
`define DSPWM_CLS_MOV       2'h2
`define DSPWM_CLS_MOVD      2'h3
// Table read kinds
`define DSPWM_TBL_NONE      2'h0
`define DSPWM_TBL_LOW       2'h1
`define DSPWM_TBL_HIGH      2'h2
// Added stall cycles
`define DSPWM_STALL_ONE     2'h1
`define DSPWM_STALL_TWO     2'h2
`define DSPWM_STALL_NONE    2'h0
`endif

/* File: hw/dspwm_mapper.v */
`timescale 1ns/1ps
`include "dspwm_map.vh"

module dspwm_mapper
(
    // Clock and reset
    input  wire                          core_clk,
    input  wire                          rst_n,
    // Core control bit and page
    input  wire                          programWindowEnable,
    input  wire [`DSPWM_PAGE_W-1:0]      programWindowPage,
    // Instruction context from the sequencer
    input  wire                          accessValid,
    input  wire [1:0]                    instrClass,
    input  wire                          macPrefetch,
    input  wire [1:0]                    tableRead,
    input  wire                          tableWrite,
    input  wire                          byteAccess,
    input  wire                          inRepeat,
    input  wire                          repeatEdge,
    // X read side
    input  wire [`DSPWM_EA_W-1:0]        xReadAddr,
    input  wire [`DSPWM_DATA_W-1:0]      xMemData,
    input  wire [`DSPWM_PWORD_W-1:0]     progWord,
    // Y read side
    input  wire                          yReadValid,
    input  wire [`DSPWM_EA_W-1:0]        yReadAddr,
    input  wire [`DSPWM_DATA_W-1:0]      yMemData,
    // Write side
    input  wire                          writeValid,
    input  wire [`DSPWM_EA_W-1:0]        writeAddr,
    input  wire [`DSPWM_DATA_W-1:0]      writeData,
    input  wire                          bitReverse,
    // Mapped addresses
    output reg  [`DSPWM_PADDR_W-1:0]     progAddr,
    output reg                           progSelect,
    output reg  [`DSPWM_EA_W-1:0]        xMemAddr,
    output reg  [`DSPWM_EA_W-1:0]        yMemAddr,
    // Returned data
    output reg  [`DSPWM_DATA_W-1:0]      xReadData,
    output reg  [`DSPWM_DATA_W-1:0]      yReadData,
    output reg                           readDone,
    // Write bus
    output reg                           xWriteEn,
    output reg  [`DSPWM_EA_W-1:0]        xWriteAddr,
    output reg  [`DSPWM_DATA_W-1:0]      xWriteData,
    output reg                           xBitReverse,
    // Stall request
    output reg  [1:0]                    stallCycles
);

////////////////////////////////////////////////////////////////////////////////

// Fixed partition; no software path can move it
function inYSpace;
    input [`DSPWM_EA_W-1:0] a;
    begin
        inYSpace = (a >= `DSPWM_Y_LO) && (a <= `DSPWM_Y_HI);
    end
endfunction

function implemented;
    input [`DSPWM_EA_W-1:0] a;
    begin
        implemented = (a >= `DSPWM_IMPL_LO) && (a <= `DSPWM_IMPL_HI);
    end
endfunction

// Byte lane pick; the chosen byte always lands in the low half
function [`DSPWM_DATA_W-1:0] byteLane;
    input [`DSPWM_DATA_W-1:0] w;
    input                     sel;
    begin
        if (sel)
            byteLane = {{`DSPWM_BYTE_W{1'b0}}, w[`DSPWM_DATA_W-1:`DSPWM_BYTE_W]};
        else
            byteLane = {{`DSPWM_BYTE_W{1'b0}}, w[`DSPWM_BYTE_W-1:0]};
    end
endfunction

// Top program byte zero-extended onto a data word
function [`DSPWM_DATA_W-1:0] highWord;
    input [`DSPWM_PWORD_W-1:0] p;
    begin
        highWord = {{`DSPWM_BYTE_W{1'b0}}, p[`DSPWM_PWORD_W-1:`DSPWM_DATA_W]};
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

// Instruction decode
wire isMac    = (instrClass == `DSPWM_CLS_MAC);
wire macFetch = isMac && macPrefetch;
wire isMove   = (instrClass == `DSPWM_CLS_MOV) || (instrClass == `DSPWM_CLS_MOVD);
wire noTable  = (tableRead == `DSPWM_TBL_NONE);
wire tableOp  = !noTable || tableWrite;
wire byteSel  = xReadAddr[`DSPWM_BYTE_SEL];
wire [`DSPWM_DATA_W-1:0] progLow = progWord[`DSPWM_DATA_W-1:0];

// Redirect only when top bit set, enabled and no table op running
wire winHit   = programWindowEnable && xReadAddr[`DSPWM_WIN_BIT] && !tableOp;

// Page above the low fifteen bits; steps of two keep data and program aligned
wire [`DSPWM_PADDR_W-1:0] winAddr =
    {programWindowPage, xReadAddr[`DSPWM_LOW_BITS-1:0]};
// Table reads reach program space with the plain data address
wire [`DSPWM_PADDR_W-1:0] tblAddr =
    {{(`DSPWM_PADDR_W-`DSPWM_EA_W){1'b0}}, xReadAddr};

reg  [`DSPWM_DATA_W-1:0] next_xReadData;
reg  [1:0]               next_stall;
reg                      xInvalid;

////////////////////////////////////////////////////////////////////////////////

// Read byte and word assembly: table reads, window reads and plain X reads
always @*
begin
    next_xReadData = {`DSPWM_DATA_W{1'b0}};
    xInvalid       = 1'b0;
    case (tableRead)
        `DSPWM_TBL_LOW:
        begin
            if (byteAccess)
            begin
                next_xReadData = byteLane(progLow, byteSel);
            end
            else
            begin
                next_xReadData = progLow;
            end
        end
        `DSPWM_TBL_HIGH:
        begin
            if (byteAccess && byteSel)
            begin
                next_xReadData = {`DSPWM_DATA_W{1'b0}};
            end
            else
            begin
                next_xReadData = highWord(progWord);
            end
        end
        default:
        begin
            if (winHit)
            begin
                // Through the window only the low sixteen program bits reach data
                if (byteAccess)
                begin
                    next_xReadData = byteLane(progLow, byteSel);
                end
                else
                begin
                    next_xReadData = progLow;
                end
            end
            else
            begin
                // Only 0000-27ff linear for non-MAC; Y also excluded for MAC prefetch reads
                xInvalid = !implemented(xReadAddr)
                         || (macFetch && inYSpace(xReadAddr));
                if (xInvalid)
                begin
                    next_xReadData = {`DSPWM_DATA_W{1'b0}};
                end
                else if (byteAccess)
                begin
                    next_xReadData = byteLane(xMemData, byteSel);
                end
                else
                begin
                    next_xReadData = xMemData;
                end
            end
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////

// Added cycles; two fetches per window access lengthen the instruction
always @*
begin
    next_stall = `DSPWM_STALL_NONE;
    if (accessValid && winHit)
    begin
        if (inRepeat)
        begin
            // Middle iterations run single-cycle, so they add nothing
            if (repeatEdge)
            begin
                next_stall = `DSPWM_STALL_TWO;
            end
            else
            begin
                next_stall = `DSPWM_STALL_NONE;
            end
        end
        else if (macFetch || isMove)
        begin
            next_stall = `DSPWM_STALL_ONE;
        end
        else
        begin
            next_stall = `DSPWM_STALL_TWO;
        end
    end
end

// Y path serves MAC prefetch only; X pointers into Y are refused above for MAC prefetch only
wire yOk  = yReadValid && macFetch;
wire yBad = !inYSpace(yReadAddr);

////////////////////////////////////////////////////////////////////////////////

// Program fetch side; one cycle from request to answer
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        progSelect <= 1'b0;
        progAddr   <= {`DSPWM_PADDR_W{1'b0}};
    end
    else
    begin
        progSelect <= accessValid && (winHit || !noTable);
        progAddr   <= winHit ? winAddr : tblAddr;
    end
end

// Read addresses pass straight to the memories
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        xMemAddr <= {`DSPWM_EA_W{1'b0}};
        yMemAddr <= {`DSPWM_EA_W{1'b0}};
    end
    else
    begin
        xMemAddr <= xReadAddr;
        yMemAddr <= yReadAddr;
    end
end

// X answer stands for one cycle; idle cycles return zero
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        xReadData <= {`DSPWM_DATA_W{1'b0}};
        readDone  <= 1'b0;
    end
    else
    begin
        xReadData <= accessValid ? next_xReadData : {`DSPWM_DATA_W{1'b0}};
        readDone  <= accessValid;
    end
end

// Y answer; refused fetches read as zero
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        yReadData <= {`DSPWM_DATA_W{1'b0}};
    end
    else
    begin
        // Modulo address arithmetic lives in the AGUs; both paths accept it
        yReadData <= (yOk && !yBad) ? yMemData : {`DSPWM_DATA_W{1'b0}};
    end
end

// Stall count travels with the answer; the sequencer applies it
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        stallCycles <= `DSPWM_STALL_NONE;
    end
    else
    begin
        stallCycles <= next_stall;
    end
end

// Every write, MAC write-back included, leaves on X
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        xWriteEn    <= 1'b0;
        xBitReverse <= 1'b0;
    end
    else
    begin
        xWriteEn    <= writeValid;
        xBitReverse <= writeValid && bitReverse;
    end
end

// Write address and data; no Y write port exists at all
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        xWriteAddr <= {`DSPWM_EA_W{1'b0}};
        xWriteData <= {`DSPWM_DATA_W{1'b0}};
    end
    else
    begin
        xWriteAddr <= writeAddr;
        xWriteData <= writeData;
    end
end

endmodule // dspwm_mapper

/* File: verif/dspwm_mapper_checker.sv */
`timescale 1ns/1ps
module dspwm_mapper_checker
(
    // Inputs
    input logic        core_clk, rst_n, programWindowEnable, accessValid, tableWrite,
    input logic        byteAccess, inRepeat, repeatEdge, writeValid, yReadValid,
    input logic [7:0]  programWindowPage,
    input logic [1:0]  tableRead,
    input logic [15:0] xReadAddr, writeAddr, writeData,
    input logic [23:0] progWord,
    // Outputs
    input logic        progSelect, xWriteEn,
    input logic [22:0] progAddr,
    input logic [15:0] xReadData, xWriteAddr, xWriteData,
    input logic [1:0]  stallCycles
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire win = programWindowEnable && xReadAddr[15] && tableRead == 2'h0 && !tableWrite;
    ////////////////////////////////////////////////////////////////////////////
    property p_lo; accessValid && tableRead == 2'h1 && !byteAccess
        |=> xReadData == $past(progWord[15:0]); endproperty
    a_lo: assert property (p_lo) else $error("low word");
    property p_hi; accessValid && tableRead == 2'h2 && !(byteAccess && xReadAddr[0])
        |=> xReadData == {8'h00, $past(progWord[23:16])}; endproperty
    a_hi: assert property (p_hi) else $error("high word");
    property p_hib; accessValid && tableRead == 2'h2 && byteAccess && xReadAddr[0]
        |=> xReadData == 16'h0000; endproperty
    a_hib: assert property (p_hib) else $error("high byte");
    property p_pa; accessValid && win |=> progSelect
        && progAddr == {$past(programWindowPage), $past(xReadAddr[14:0])}; endproperty
    a_pa: assert property (p_pa) else $error("window address");
    property p_pd; accessValid && win && !byteAccess
        |=> xReadData == $past(progWord[15:0]); endproperty
    a_pd: assert property (p_pd) else $error("window data");
    property p_rep; accessValid && win && inRepeat
        |=> stallCycles == ($past(repeatEdge) ? 2'h2 : 2'h0); endproperty
    a_rep: assert property (p_rep) else $error("repeat stall");
    property p_nost; accessValid && !win |=> stallCycles == 2'h0; endproperty
    a_nost: assert property (p_nost) else $error("plain stall");
    property p_wr; writeValid |=> xWriteEn
        && xWriteAddr == $past(writeAddr) && xWriteData == $past(writeData); endproperty
    a_wr: assert property (p_wr) else $error("write bus");
    c_win: cover property (accessValid && win && inRepeat);
    c_hi: cover property (accessValid && tableRead == 2'h2);
    c_wy: cover property (writeValid && yReadValid);
endmodule // dspwm_mapper_checker

bind dspwm_mapper dspwm_mapper_checker u_dspwm_mapper_checker (.core_clk, .rst_n,
    .programWindowEnable, .accessValid, .tableWrite, .byteAccess, .inRepeat, .repeatEdge,
    .writeValid, .yReadValid, .programWindowPage, .tableRead, .xReadAddr, .writeAddr,
    .writeData, .progWord, .progSelect, .xWriteEn, .progAddr, .xReadData, .xWriteAddr,
    .xWriteData, .stallCycles);

/* File: verif/dspwm_mem_model.sv */
`timescale 1ns/1ps
// Memory side: contents follow the address, so a misrouted fetch shows
module dspwm_mem_model
(
    // Read addresses and page
    input  wire [15:0] xa, ya,
    input  wire [7:0]  page,
    // Read data
    output wire [23:0] pw,
    output wire [15:0] xm, ym
);
    assign pw = {xa[7:0] ^ page, xa[15:8] ^ 8'h3c, ~xa[7:0]};
    assign xm = {xa[7:0] ^ 8'h96, xa[15:8] + 8'h11};
    assign ym = {ya[7:0], ~ya[15:8]};
endmodule // dspwm_mem_model

/* File: verif/test_dspwm_mapper.sv */
`timescale 1ns/1ps
module test_dspwm_mapper;
    reg         core_clk = 0, rst_n = 0, en = 0, av = 0, mp = 0, tw = 0, ba = 0, rep = 0;
    reg         edg = 0, yv = 0, wv = 0, br = 0, win, pAv = 0, pWin = 0, pMap = 0, pYv = 0;
    reg         pWv = 0;
    reg  [7:0]  page = 8'h00;
    reg  [1:0]  cls = 2'h0, tr = 2'h0, eS = 2'h0;
    reg  [15:0] xa = 16'h0000, ya = 16'h0000, wa = 16'h0000, wd = 16'h0000, eD = 0, eY = 0;
    reg  [22:0] eA = 0;
    reg  [31:0] eM = 0;
    reg  [32:0] eW = 0;
    reg  [31:0] r;
    integer     seed = 32'hc13a, fails = 0, testsRun = 0, i, m;
    wire [23:0] pw;
    wire [15:0] xm, ym, xRd, yRd, wAd, wDt, xMA, yMA;
    wire [22:0] pAd;
    wire [1:0]  stl;
    wire        pSel, done, wEn, wBr;
    always #4 core_clk = ~core_clk;
    dspwm_mem_model u_dspwm_mem_model (.xa(xa), .ya(ya), .page(page), .pw(pw), .xm(xm), .ym(ym));
    dspwm_mapper u_dspwm_mapper (.core_clk(core_clk), .rst_n(rst_n), .programWindowEnable(en),
        .programWindowPage(page), .accessValid(av), .instrClass(cls), .macPrefetch(mp),
        .tableRead(tr), .tableWrite(tw), .byteAccess(ba), .inRepeat(rep), .repeatEdge(edg),
        .xReadAddr(xa), .xMemData(xm), .progWord(pw), .yReadValid(yv), .yReadAddr(ya),
        .yMemData(ym), .writeValid(wv), .writeAddr(wa), .writeData(wd), .bitReverse(br),
        .progAddr(pAd), .progSelect(pSel), .xMemAddr(xMA), .yMemAddr(yMA), .xReadData(xRd),
        .yReadData(yRd), .readDone(done), .xWriteEn(wEn), .xWriteAddr(wAd), .xWriteData(wDt),
        .xBitReverse(wBr), .stallCycles(stl));
    ////////////////////////////////////////////////////////////////////////////
    task cmp(input [63:0] nm, input [32:0] e, input [32:0] g);
        begin
            testsRun = testsRun + 1;
            if (e !== g)
            begin
                fails = fails + 1;
                $display("[ERR] %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task testDone;
        begin
            $display("checks %0d mismatches %0d", testsRun, fails);
            if (fails == 0 && testsRun > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // Random request; mode 1 forces the window enable on and, when r[9] is clear, address bit 15
    task drive(input integer mode);
        begin
            r = $random(seed);
            {edg, rep, ba, br, wv, yv, av, en} = {r[7:2], r[1] | r[8], r[0] | mode[0]};
            {page, cls, mp} = {r[15:8], r[17:16], r[18] & (r[17:16] == 2'h1)};
            tr = (r[20:19] == 2'h3) ? 2'h0 : r[20:19];
            tw = &r[23:21];
            xa = r[31:24] << 8 | r[7:0];
            if (!r[9])
                xa = (xa % 16'h2800) | {mode[0] | r[10], 15'h0000};
            if (!ba)
                xa[0] = 1'b0;
            r = $random(seed);
            {ya, wa} = {r[15:0] % 16'h3000, r[31:16]};
            r = $random(seed);
            wd = r[15:0];
            #1;
            win = en && xa[15] && tr == 2'h0 && !tw;
            eD = ba ? {8'h00, xa[0] ? pw[15:8] : pw[7:0]} : pw[15:0];
            if (tr == 2'h2)
                eD = (ba && xa[0]) ? 16'h0000 : {8'h00, pw[23:16]};
            else if (tr == 2'h0 && !win)
                eD = (xa > 16'h27ff || (mp && xa >= 16'h1800)) ? 16'h0000
                    : ba ? {8'h00, xa[0] ? xm[15:8] : xm[7:0]} : xm;
            if (!av)
                eD = 16'h0000;
            eS = !win ? 2'h0 : rep ? {edg, 1'b0} : (cls != 2'h0 && (cls != 2'h1 || mp)) ? 2'h1 : 2'h2;
            eY = (mp && ya >= 16'h1800 && ya <= 16'h27ff) ? ym : 16'h0000;
            eA = win ? {page, xa[14:0]} : {7'h00, xa};
            eM = {xa, ya};
            {eW, pAv, pWin, pMap, pYv, pWv} = {wa, wd, br, av, win, tr == 2'h0, yv, wv};
        end
    endtask
    task check;
        begin
            cmp("rdata", eD, xRd);
            cmp("done", pAv, done);
            if (pAv) cmp("stall", eS, stl);
            if (pAv && pMap) cmp("psel", pWin, pSel);
            if (pAv && pWin) cmp("paddr", eA, pAd);
            if (pAv && !pMap) cmp("taddr", eA, pAd);
            if (pAv && !pMap) cmp("tsel", 1'b1, pSel);
            cmp("maddr", eM, {xMA, yMA});
            if (pYv) cmp("ydata", eY, yRd);
            cmp("wen", pWv, wEn);
            if (pWv) cmp("wbus", eW, {wAd, wDt, wBr});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        for (m = 0; m < 2; m = m + 1)
        begin
            for (i = 0; i < 400; i = i + 1)
            begin
                @(negedge core_clk);
                check;
                drive(m);
            end
            $display("test %0d ended, mismatches %0d", m, fails);
        end
        @(negedge core_clk);
        check;
        testDone;
    end
    // About three times the 800 cycles the tests need
    initial
    begin
        #20000;
        fails = fails + 1;
        testDone;
    end
endmodule // test_dspwm_mapper
